//--- gdt_cfg_bank.sv
// Gate drive timing and current configuration register bank, addresses 0x05 to 0x08.
// Assumes a frame decoder that presents one decoded register access per frame.
`timescale 1ns/100ps
module gdt_cfg_bank (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic frame_valid_i,
  input wire logic frame_operation_bit_i,
  input wire logic [gdt_pkg::ADDR_W-1:0] frame_addr_i,
  input wire logic [gdt_pkg::DATA_W-1:0] frame_wdata_i,
  output logic addr_hit_o,
  output logic [gdt_pkg::DATA_W-1:0] read_data_o,
  output logic read_valid_o,
  input wire logic current_extension_select_i,
  input wire logic global_error_i,
  input wire logic phase1_back_emf_i,
  input wire logic phase2_back_emf_i,
  input wire logic phase3_back_emf_i,
  output logic global_error_flag_o,
  output logic [1:0] charge_phase_time_o,
  output logic [gdt_pkg::CYC_W-1:0] charge_phase_cycles_o,
  output logic [1:0] pre_discharge_time_o,
  output logic [gdt_pkg::CYC_W-1:0] pre_discharge_cycles_o,
  output logic [gdt_pkg::CUR_W-1:0] charge_current_o,
  output logic [gdt_pkg::CUR_W-1:0] post_charge_current_o,
  output logic [gdt_pkg::CUR_W-1:0] pre_discharge_current_o,
  output logic [gdt_pkg::CUR_W-1:0] gate_hold_current_o,
  output logic [gdt_pkg::CUR_W-1:0] discharge_current_o
);
  import gdt_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // Address decode.

  logic [DATA_W-1:0] cfg_reg [NUM_CFG];
  logic [DATA_W-1:0] cfg_next [NUM_CFG];

  // The bank is one contiguous range, so a subtract and two offset bits index it;
  // growing the bank means widening bank_index as well.
  wire in_bank = (frame_addr_i >= CHARGE_TIME_CURRENT_CFG_ADDR) &&
                 (frame_addr_i <= HOLD_DISCHARGE_CURRENT_CFG_ADDR);
  wire [ADDR_W-1:0] bank_offset = frame_addr_i - CHARGE_TIME_CURRENT_CFG_ADDR;
  wire [1:0] bank_index = bank_offset[1:0];
  wire write_req = frame_valid_i && in_bank && frame_operation_bit_i;
  wire read_req = frame_valid_i && in_bank && !frame_operation_bit_i;

  // Other registers of the device live elsewhere; the hit tells the frame decoder
  // whether this bank owns the access.
  assign addr_hit_o = in_bank;

  ////////////////////////////////////////////////////////////////////////////////
  // Register storage. Nothing but a host write moves a register after reset,
  // so protection events elsewhere never disturb the programmed gate profile.

  genvar r;
  generate
    for (r = 0; r < NUM_CFG; r++) begin : g_cfg
      wire hit = write_req && (bank_index == 2'(r));
      assign cfg_next[r] = hit ? frame_wdata_i : cfg_reg[r];
      always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
          cfg_reg[r] <= CFG_RESET_VALUE;
        end else begin
          cfg_reg[r] <= cfg_next[r];
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // Read path: the whole register word is returned in one frame.

  logic [DATA_W-1:0] read_data_reg;
  logic [DATA_W-1:0] read_data_next;
  logic read_valid_reg;
  logic read_valid_next;

  // A read outside the bank neither pulses the valid nor disturbs the last word, so
  // the frame decoder may return that word late without a second access.
  assign read_data_next = read_req ? cfg_reg[bank_index] : read_data_reg;
  assign read_valid_next = read_req;

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      read_data_reg <= '0;
      read_valid_reg <= 1'b0;
    end else begin
      read_data_reg <= read_data_next;
      read_valid_reg <= read_valid_next;
    end
  end

  assign read_data_o = read_data_reg;
  assign read_valid_o = read_valid_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // Field extraction.

  wire [1:0] charge_time_sel = cfg_reg[IDX_CHG][SEL_MSB:SEL_LSB];
  wire [5:0] charge_current_code = cfg_reg[IDX_CHG][CODE_MSB:CODE_LSB];
  wire [1:0] error_flag_source_select = cfg_reg[IDX_POST][SEL_MSB:SEL_LSB];
  wire [5:0] post_charge_current_code = cfg_reg[IDX_POST][CODE_MSB:CODE_LSB];
  wire [1:0] predis_time_sel = cfg_reg[IDX_PREDIS][SEL_MSB:SEL_LSB];
  wire [5:0] pre_discharge_current_code = cfg_reg[IDX_PREDIS][CODE_MSB:CODE_LSB];
  wire [1:0] gate_hold_current_code = cfg_reg[IDX_HOLDDIS][SEL_MSB:SEL_LSB];
  wire [5:0] discharge_current_code = cfg_reg[IDX_HOLDDIS][CODE_MSB:CODE_LSB];

  ////////////////////////////////////////////////////////////////////////////////
  // Current decoding through the shared tables.

  // One decoder serves all five channels, so each current table exists only once.
  gdt_cur_if cur_bus ();

  assign cur_bus.ext_sel = current_extension_select_i;
  assign cur_bus.code[CH_CHARGE] = charge_current_code;
  assign cur_bus.code[CH_POST] = post_charge_current_code;
  assign cur_bus.code[CH_PREDIS] = pre_discharge_current_code;
  // The four hold levels sit on the shared table, so the hold field is remapped.
  assign cur_bus.code[CH_HOLD] = HOLD_LEVEL_CODE[gate_hold_current_code];
  assign cur_bus.code[CH_DIS] = discharge_current_code;

  gdt_cur_decode u_decode (
    .cur(cur_bus)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Phase durations in reference clock cycles.
  // Durations round up to whole cycles, so no phase is ever shorter than programmed;
  // 150 ns and 250 ns therefore last 8 and 13 cycles.

  wire [CYC_W-1:0] charge_cycles_next = gdt_ns_to_cycles(CHARGE_TIME_NS[charge_time_sel]);
  wire [CYC_W-1:0] predis_cycles_next =
    gdt_ns_to_cycles(PRE_DISCHARGE_TIME_NS[predis_time_sel]);

  ////////////////////////////////////////////////////////////////////////////////
  // Error flag source selection.
  // The flag is registered like every data output: one cycle of latency on a back-EMF
  // edge buys a pin that never shows a decode glitch when the selection changes.

  gdt_flag_src_e flag_src;
  logic flag_next;

  assign flag_src = gdt_flag_src_e'(error_flag_source_select);

  always_comb begin
    unique case (flag_src)
      GDT_FLAG_GLOBAL: flag_next = global_error_i;
      GDT_FLAG_PHASE1: flag_next = phase1_back_emf_i;
      GDT_FLAG_PHASE2: flag_next = phase2_back_emf_i;
      GDT_FLAG_PHASE3: flag_next = phase3_back_emf_i;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Output registers. Two cycles after a write the sequencer sees the new value,
  // which is well ahead of the next switching phase.

  logic flag_reg;
  logic [CYC_W-1:0] charge_cycles_reg;
  logic [CYC_W-1:0] predis_cycles_reg;
  logic [CUR_W-1:0] level_reg [NUM_CUR];

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      flag_reg <= 1'b0;
    end else begin
      flag_reg <= flag_next;
    end
  end

  // Until the first edge after reset release these outputs read zero, so the
  // sequencer has to let one cycle pass before it starts a phase.
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      charge_cycles_reg <= '0;
      predis_cycles_reg <= '0;
    end else begin
      charge_cycles_reg <= charge_cycles_next;
      predis_cycles_reg <= predis_cycles_next;
    end
  end

  genvar c;
  generate
    for (c = 0; c < NUM_CUR; c++) begin : g_lvl
      wire [CUR_W-1:0] level_next = cur_bus.level[c];
      always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
          level_reg[c] <= '0;
        end else begin
          level_reg[c] <= level_next;
        end
      end
    end
  endgenerate

  assign global_error_flag_o = flag_reg;
  assign charge_phase_time_o = charge_time_sel;
  assign charge_phase_cycles_o = charge_cycles_reg;
  assign pre_discharge_time_o = predis_time_sel;
  assign pre_discharge_cycles_o = predis_cycles_reg;
  assign charge_current_o = level_reg[CH_CHARGE];
  assign post_charge_current_o = level_reg[CH_POST];
  assign pre_discharge_current_o = level_reg[CH_PREDIS];
  assign gate_hold_current_o = level_reg[CH_HOLD];
  assign discharge_current_o = level_reg[CH_DIS];

endmodule

//--- gdt_cfg_bank_chk.sv
// Checker for the configuration bank's frame port and time fields.
// Assumes it is bound to gdt_cfg_bank and sees only its ports.
`timescale 1ns/100ps
module gdt_cfg_bank_chk import gdt_pkg::*; (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic frame_valid_i,
  input wire logic frame_operation_bit_i,
  input wire logic [gdt_pkg::ADDR_W-1:0] frame_addr_i,
  input wire logic [gdt_pkg::DATA_W-1:0] frame_wdata_i,
  input wire logic addr_hit_o,
  input wire logic [gdt_pkg::DATA_W-1:0] read_data_o,
  input wire logic read_valid_o,
  input wire logic [1:0] charge_phase_time_o,
  input wire logic [gdt_pkg::CYC_W-1:0] charge_phase_cycles_o,
  input wire logic [1:0] pre_discharge_time_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  wire logic rd_hit = frame_valid_i & ~frame_operation_bit_i & addr_hit_o;
  wire logic wr_hit = frame_valid_i & frame_operation_bit_i & addr_hit_o;
  wire logic wr_chg = wr_hit & (frame_addr_i == 7'h05);
  wire logic wr_pre = wr_hit & (frame_addr_i == 7'h07);
  wire logic [1:0] wsel = frame_wdata_i[7:6];
  AST_ADDR_DECODE: assert property
    (addr_hit_o == (frame_addr_i >= 7'h05 && frame_addr_i <= 7'h08))
    else $error("address decode wrong");
  AST_READ_ANSWER: assert property (rd_hit |=> read_valid_o)
    else $error("read unanswered");
  AST_READ_ONLY_ON_HIT: assert property (!rd_hit |=> !read_valid_o)
    else $error("spurious read");
  AST_READ_HOLDS: assert property (!rd_hit |=> $stable(read_data_o))
    else $error("read data moved");
  AST_WRITE_READBACK: assert property
    (wr_hit ##1 (rd_hit && frame_addr_i == $past(frame_addr_i))
    |=> read_data_o == $past(frame_wdata_i, 2)) else $error("readback differs");
  AST_CHARGE_TIME: assert property (wr_chg |=> charge_phase_time_o == $past(wsel))
    else $error("charge time field wrong");
  AST_CHARGE_CYCLES: assert property (wr_chg ##1 !wr_chg
    |=> charge_phase_cycles_o == 8'h0a * (8'h01 + $past(wsel, 2)))
    else $error("charge cycles wrong");
  AST_CHARGE_STEADY: assert property (!wr_chg |=> $stable(charge_phase_time_o))
    else $error("charge time changed unasked");
  AST_PREDIS_TIME: assert property (wr_pre |=> pre_discharge_time_o == $past(wsel))
    else $error("pre-discharge time wrong");
  cover property (rd_hit);
  cover property (wr_chg);
  cover property (frame_valid_i && !addr_hit_o);
endmodule
bind gdt_cfg_bank gdt_cfg_bank_chk chk_u (.ref_clk_i, .rst_n_i, .frame_valid_i,
  .frame_operation_bit_i, .frame_addr_i, .frame_wdata_i, .addr_hit_o, .read_data_o,
  .read_valid_o, .charge_phase_time_o, .charge_phase_cycles_o, .pre_discharge_time_o);

//--- gdt_cur_decode.sv
// Current code decoder: maps each 6-bit code through the normal or extended table.
// Assumes the codes and the extension select are stable register outputs.
`timescale 1ns/100ps
module gdt_cur_decode (
  gdt_cur_if.table_side cur
);
  import gdt_pkg::*;

  genvar i;
  generate
    for (i = 0; i < NUM_CUR; i++) begin : g_ch
      wire [CUR_W-1:0] norm_level = CUR_W'(CUR_NORM_TENTH_MA[cur.code[i]]);
      wire [CUR_W-1:0] ext_level = CUR_W'(CUR_EXT_TENTH_MA[cur.code[i]]);
      assign cur.level[i] = cur.ext_sel ? ext_level : norm_level;
    end
  endgenerate

endmodule

//--- gdt_cur_if.sv
// Interface carrying current codes to the table decoder and decoded levels back.
// Assumes gdt_pkg is compiled first.
`timescale 1ns/100ps
interface gdt_cur_if;
  import gdt_pkg::*;
  logic ext_sel;
  logic [5:0] code [NUM_CUR];
  logic [CUR_W-1:0] level [NUM_CUR];
  modport table_side (input ext_sel, input code, output level);
  modport user_side (output ext_sel, output code, input level);
endinterface

//--- gdt_host_model.sv
// Host model that issues decoded register frames to the configuration bank.
// Assumes frames are driven after the falling clock edge.
`timescale 1ns/100ps
module gdt_host_model import gdt_pkg::*; (
  input wire logic ref_clk_i,
  output logic frame_valid_o,
  output logic frame_operation_bit_o,
  output logic [gdt_pkg::ADDR_W-1:0] frame_addr_o,
  output logic [gdt_pkg::DATA_W-1:0] frame_wdata_o
);
  initial begin
    frame_valid_o = 1'b0;
    frame_operation_bit_o = 1'b0;
    frame_addr_o = 7'h00;
    frame_wdata_o = 8'h00;
  end
  // Only this model changes the bank, one word per frame.
  task automatic access(input logic op, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    frame_valid_o = 1'b1;
    frame_operation_bit_o = op;
    frame_addr_o = a;
    frame_wdata_o = d;
    @(posedge ref_clk_i);
    @(negedge ref_clk_i);
  endtask
  // Released address and data lines are inverted, while the operation bit keeps its value, so a stale value can never pass for a frame.
  task automatic idle();
    frame_valid_o = 1'b0;
    frame_addr_o = ~frame_addr_o;
    frame_wdata_o = ~frame_wdata_o;
    @(negedge ref_clk_i);
  endtask
endmodule

//--- gdt_pkg.sv
// Package for the gate drive timing and current configuration bank.
// Assumes a 50 MHz reference clock and a 7-bit register address from the frame decoder.
package gdt_pkg;

  localparam int ADDR_W = 7;
  localparam int DATA_W = 8;
  localparam int CUR_W = 13;
  localparam int CYC_W = 8;
  localparam int NUM_CFG = 4;
  localparam int NUM_CUR = 5;

  localparam logic [ADDR_W-1:0] CHARGE_TIME_CURRENT_CFG_ADDR = 7'h05;
  localparam logic [ADDR_W-1:0] ERROR_FLAG_SELECT_POSTCHARGE_CFG_ADDR = 7'h06;
  localparam logic [ADDR_W-1:0] PREDISCHARGE_TIME_CURRENT_CFG_ADDR = 7'h07;
  localparam logic [ADDR_W-1:0] HOLD_DISCHARGE_CURRENT_CFG_ADDR = 7'h08;
  localparam logic [DATA_W-1:0] CFG_RESET_VALUE = 8'h0f;

  // Field layout shared by all four registers.
  localparam int SEL_MSB = 7;
  localparam int SEL_LSB = 6;
  localparam int CODE_MSB = 5;
  localparam int CODE_LSB = 0;

  // Register indices within the bank.
  localparam int IDX_CHG = 0;
  localparam int IDX_POST = 1;
  localparam int IDX_PREDIS = 2;
  localparam int IDX_HOLDDIS = 3;

  // Current channel indices.
  localparam int CH_CHARGE = 0;
  localparam int CH_POST = 1;
  localparam int CH_PREDIS = 2;
  localparam int CH_HOLD = 3;
  localparam int CH_DIS = 4;

  typedef enum logic [1:0] {
    GDT_FLAG_GLOBAL,
    GDT_FLAG_PHASE1,
    GDT_FLAG_PHASE2,
    GDT_FLAG_PHASE3
  } gdt_flag_src_e;

  localparam int CLK_PERIOD_NS = 20;
  localparam int CHARGE_TIME_NS [4] = '{200, 400, 600, 800};
  localparam int PRE_DISCHARGE_TIME_NS [4] = '{100, 150, 200, 250};

  // Phase durations are minimum times, so partial cycles round up.
  function automatic logic [CYC_W-1:0] gdt_ns_to_cycles(input int ns);
    return CYC_W'((ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  endfunction

  // Hold current levels are four points of the shared current table.
  localparam logic [5:0] HOLD_LEVEL_CODE [4] = '{6'h00, 6'h05, 6'h09, 6'h0c};

  // Current tables in units of 0.1 mA.
  localparam int CUR_NORM_TENTH_MA [64] = '{
    116, 148, 181, 213, 245, 277, 310, 342, 374, 406, 439, 471, 503, 536, 568, 600,
    654, 708, 761, 815, 869, 923, 976, 1030, 1084, 1138, 1191, 1245, 1299, 1353, 1406, 1460,
    1529, 1598, 1666, 1735, 1804, 1872, 1941, 2010, 2079, 2148, 2216, 2285, 2354, 2423, 2491,
    2560, 2634, 2709, 2783, 2858, 2932, 3006, 3081, 3155, 3230, 3304, 3378, 3453, 3527, 3602,
    3676, 3750};
  localparam int CUR_EXT_TENTH_MA [64] = '{
    116, 158, 201, 243, 285, 327, 370, 412, 454, 497, 539, 581, 624, 666, 708, 750,
    821, 893, 964, 1035, 1116, 1178, 1249, 1320, 1391, 1463, 1534, 1605, 1676, 1748, 1819, 1890,
    1978, 2066, 2154, 2242, 2331, 2419, 2507, 2595, 2683, 2771, 2859, 2947, 3035, 3123, 3212,
    3300, 3394, 3488, 3581, 3675, 3768, 3862, 3956, 4050, 4144, 4238, 4331, 4425, 4519, 4613,
    4706, 4800};

endpackage

//--- tb_gdt_cfg_bank.sv
// Self-checking bench for the configuration bank.
// Assumes the host model drives frames and the bench drives the level inputs.
`timescale 1ns/100ps
module tb_gdt_cfg_bank;
  import gdt_pkg::*;
  logic ref_clk_i = 1'b0, rst_n_i = 1'b0, ext = 1'b0, frame_valid_i, frame_operation_bit_i;
  logic addr_hit_o, read_valid_o, global_error_flag_o;
  logic [3:0] src = 4'h0;
  logic [1:0] charge_phase_time_o, pre_discharge_time_o;
  logic [ADDR_W-1:0] frame_addr_i;
  logic [DATA_W-1:0] frame_wdata_i, read_data_o;
  logic [CYC_W-1:0] charge_phase_cycles_o, pre_discharge_cycles_o;
  logic [CUR_W-1:0] charge_current_o, post_charge_current_o, pre_discharge_current_o;
  logic [CUR_W-1:0] gate_hold_current_o, discharge_current_o;
  int error_cnt = 0, total_checks = 0;
  gdt_host_model host_u (.ref_clk_i, .frame_valid_o(frame_valid_i),
    .frame_operation_bit_o(frame_operation_bit_i), .frame_addr_o(frame_addr_i),
    .frame_wdata_o(frame_wdata_i));
  gdt_cfg_bank dut_u (.ref_clk_i, .rst_n_i, .frame_valid_i, .frame_operation_bit_i,
    .frame_addr_i, .frame_wdata_i, .addr_hit_o, .read_data_o, .read_valid_o,
    .current_extension_select_i(ext), .global_error_i(src[0]), .phase1_back_emf_i(src[1]),
    .phase2_back_emf_i(src[2]), .phase3_back_emf_i(src[3]), .global_error_flag_o,
    .charge_phase_time_o, .charge_phase_cycles_o, .pre_discharge_time_o,
    .pre_discharge_cycles_o, .charge_current_o, .post_charge_current_o,
    .pre_discharge_current_o, .gate_hold_current_o, .discharge_current_o);
  initial begin
    forever #10 ref_clk_i = ~ref_clk_i;
  end
  task automatic chk(input logic [CUR_W-1:0] seen, input logic [CUR_W-1:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: seen %0d expected %0d", $time, seen, exp);
    end
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    host_u.access(1'b0, a, 8'h00);
    chk(CUR_W'(read_valid_o), 13'h1);
    chk(CUR_W'(read_data_o), CUR_W'(exp));
  endtask
  task automatic t_reset();
    for (int a = 5; a <= 8; a++) rd(ADDR_W'(a), 8'h0f);
    host_u.idle();
    chk(CUR_W'(charge_phase_cycles_o), 13'd10);
    chk(CUR_W'(pre_discharge_cycles_o), 13'd5);
    chk(charge_current_o, 13'd600);
    chk(post_charge_current_o, 13'd600);
    chk(gate_hold_current_o, 13'd116);
  endtask
  task automatic t_times();
    int pre_cyc [4] = '{5, 8, 10, 13};
    for (int i = 0; i < 4; i++) begin
      host_u.access(1'b1, 7'h05, {i[1:0], 6'h3f});
      host_u.access(1'b1, 7'h07, {i[1:0], 6'h00});
      host_u.idle();
      chk(CUR_W'(charge_phase_cycles_o), CUR_W'(10 * (i + 1)));
      chk(CUR_W'(pre_discharge_cycles_o), CUR_W'(pre_cyc[i]));
      chk(CUR_W'(charge_phase_time_o), CUR_W'(i));
      chk(CUR_W'(pre_discharge_time_o), CUR_W'(i));
      chk(charge_current_o, 13'd3750);
      chk(pre_discharge_current_o, 13'd116);
    end
    ext = 1'b1;
    @(negedge ref_clk_i);
    chk(charge_current_o, 13'd4800);
    chk(pre_discharge_current_o, 13'd116);
    ext = 1'b0;
  endtask
  task automatic t_hold();
    int hold [4] = '{116, 277, 406, 503};
    for (int i = 0; i < 4; i++) begin
      host_u.access(1'b1, 7'h08, {i[1:0], 6'h3f});
      host_u.idle();
      chk(gate_hold_current_o, CUR_W'(hold[i]));
      chk(discharge_current_o, 13'd3750);
    end
    ext = 1'b1;
    @(negedge ref_clk_i);
    chk(gate_hold_current_o, 13'd624);
    chk(discharge_current_o, 13'd4800);
    ext = 1'b0;
  endtask
  task automatic t_flag();
    for (int i = 0; i < 4; i++) begin
      host_u.access(1'b1, 7'h06, {i[1:0], 6'h00});
      host_u.idle();
      src = 4'h1 << i;
      @(negedge ref_clk_i);
      chk(CUR_W'(global_error_flag_o), 13'h1);
      src = ~(4'h1 << i);
      @(negedge ref_clk_i);
      chk(CUR_W'(global_error_flag_o), 13'h0);
    end
    chk(post_charge_current_o, 13'd116);
  endtask
  // Back-to-back write and read, then frames outside the bank that must be ignored.
  task automatic t_miss();
    host_u.access(1'b1, 7'h06, 8'h5a);
    rd(7'h06, 8'h5a);
    host_u.access(1'b0, 7'h09, 8'h00);
    chk(CUR_W'(read_valid_o), 13'h0);
    chk(CUR_W'(addr_hit_o), 13'h0);
    host_u.access(1'b1, 7'h04, 8'h00);
    chk(CUR_W'(read_data_o), 13'h5a);
    rd(7'h05, 8'hff);
    host_u.idle();
  endtask
  // A reset in mid-run must bring every programmed register back to its default.
  task automatic t_rerst();
    rst_n_i = 1'b0;
    repeat (2) @(negedge ref_clk_i);
    rst_n_i = 1'b1;
    @(negedge ref_clk_i);
    for (int a = 5; a <= 8; a++) rd(ADDR_W'(a), 8'h0f);
    host_u.idle();
    chk(CUR_W'(charge_phase_cycles_o), 13'd10);
    chk(CUR_W'(pre_discharge_cycles_o), 13'd5);
    chk(gate_hold_current_o, 13'd116);
    chk(discharge_current_o, 13'd600);
  endtask
  task automatic print_verdict();
    if (error_cnt == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    #(20 * 3000);
    error_cnt++;
    print_verdict();
  end
  initial begin
    repeat (10) @(negedge ref_clk_i);
    rst_n_i = 1'b1;
    @(negedge ref_clk_i);
    t_reset();
    t_times();
    t_hold();
    t_flag();
    t_miss();
    t_rerst();
    print_verdict();
  end
endmodule
